// [csf_alu.sv]
// Purpose: Combinational arithmetic and logic unit with flag generation.
// Assumes: Operand a is the working register, operand b comes from memory.
// Notes:   Subtraction is a plus the inverted b plus one, so carry means no borrow.
`timescale 1ns/1ns
module csf_alu
  import csf_pkg::*;
(
  // Operation and operands.
  input  wire csf_alu_op_t      op_i,
  input  wire logic [7:0]       a_i,
  input  wire logic [7:0]       b_i,
  input  wire logic             carry_i,
  // Result and flags.
  output logic [7:0]            res_o,
  output logic [3:0]            flag_o,
  output logic [3:0]            upd_o
);

  logic       is_sub;
  logic       is_arith;
  logic [7:0] b_x;
  logic [8:0] sum9;
  logic [4:0] lo5;
  logic [7:0] lo8;

  assign is_sub   = (op_i == CSF_OP_SUB);
  assign is_arith = (op_i == CSF_OP_ADD) || is_sub;
  assign b_x      = is_sub ? ~b_i : b_i;
  assign sum9     = {1'b0, a_i} + {1'b0, b_x} + {8'h00, is_sub};
  assign lo5      = {1'b0, a_i[3:0]} + {1'b0, b_x[3:0]} + {4'h0, is_sub};
  assign lo8      = {1'b0, a_i[6:0]} + {1'b0, b_x[6:0]} + {7'h00, is_sub};

  always_comb begin
    res_o  = b_i;
    flag_o = 4'h0;
    upd_o  = 4'h0;
    case (op_i)
      CSF_OP_ADD, CSF_OP_SUB: res_o = sum9[7:0];
      CSF_OP_AND:  res_o = a_i & b_i;
      CSF_OP_OR:   res_o = a_i | b_i;
      CSF_OP_XOR:  res_o = a_i ^ b_i;
      CSF_OP_PASS: res_o = b_i;
      CSF_OP_RLC:  res_o = {b_i[6:0], carry_i};
      CSF_OP_RRC:  res_o = {carry_i, b_i[7:1]};
      default:     res_o = b_i;
    endcase
    if (is_arith) begin
      flag_o[CSF_ST_C]  = sum9[8];           // [RULE11]
      flag_o[CSF_ST_AC] = lo5[4];            // [RULE12]
      flag_o[CSF_ST_OV] = lo8[7] ^ sum9[8];  // [RULE14]
      upd_o[CSF_ST_C]   = 1'b1;
      upd_o[CSF_ST_AC]  = 1'b1;
      upd_o[CSF_ST_OV]  = 1'b1;
    end
    if (op_i == CSF_OP_RLC) begin
      flag_o[CSF_ST_C] = b_i[7];             // [RULE11]
      upd_o[CSF_ST_C]  = 1'b1;
    end
    if (op_i == CSF_OP_RRC) begin
      flag_o[CSF_ST_C] = b_i[0];             // [RULE11]
      upd_o[CSF_ST_C]  = 1'b1;
    end
    if (op_i != CSF_OP_PASS && op_i != CSF_OP_RLC && op_i != CSF_OP_RRC) begin
      flag_o[CSF_ST_Z] = (res_o == CSF_BYTE_ZERO); // [RULE13]
      upd_o[CSF_ST_Z]  = 1'b1;
    end
  end

endmodule : csf_alu

// [csf_pkg.sv]
// Purpose: Shared constants and types of the core special function registers.
// Assumes: An 8-bit data path and a 7-bit bank-0 data memory address.
// Notes:   Register addresses and status bit positions are collected here.
package csf_pkg;

  localparam int unsigned CSF_ADDR_W = 7;
  localparam int unsigned CSF_DATA_W = 8;
  localparam int unsigned CSF_GP_W   = 6;

  // Special function register addresses in bank 0.
  localparam logic [CSF_ADDR_W-1:0] CSF_ADDR_IAP    = 7'h00;
  localparam logic [CSF_ADDR_W-1:0] CSF_ADDR_MP0    = 7'h01;
  localparam logic [CSF_ADDR_W-1:0] CSF_ADDR_ACC    = 7'h05;
  localparam logic [CSF_ADDR_W-1:0] CSF_ADDR_PCL    = 7'h06;
  localparam logic [CSF_ADDR_W-1:0] CSF_ADDR_TBLP   = 7'h07;
  localparam logic [CSF_ADDR_W-1:0] CSF_ADDR_TABLE_READ_HIGH_LATCH   = 7'h08;
  localparam logic [CSF_ADDR_W-1:0] CSF_ADDR_TBHP   = 7'h09;
  localparam logic [CSF_ADDR_W-1:0] CSF_ADDR_STATUS = 7'h0a;
  localparam logic [CSF_ADDR_W-1:0] CSF_ADDR_GP     = 7'h40;

  // Status register bit positions.
  localparam int unsigned CSF_ST_C   = 0;
  localparam int unsigned CSF_ST_AC  = 1;
  localparam int unsigned CSF_ST_Z   = 2;
  localparam int unsigned CSF_ST_OV  = 3;
  localparam int unsigned CSF_ST_PDF = 4;
  localparam int unsigned CSF_ST_TO  = 5;
  localparam int unsigned CSF_ARITH_W = 4;

  localparam logic [CSF_DATA_W-1:0] CSF_BYTE_ZERO = 8'h00;
  localparam logic [1:0]            CSF_ST_HI_ZERO = 2'h0;
  localparam logic                  CSF_SYS_FLAG_RST = 1'b0;

  // Operations of the arithmetic and logic unit.
  typedef enum logic [2:0] {
    CSF_OP_ADD,
    CSF_OP_SUB,
    CSF_OP_AND,
    CSF_OP_OR,
    CSF_OP_XOR,
    CSF_OP_PASS,
    CSF_OP_RLC,
    CSF_OP_RRC
  } csf_alu_op_t;

endpackage : csf_pkg

// [csf_prog_model.sv]
// Purpose: Program side partner of the special function registers.
// Assumes: Table pointer and jump outputs come from csf_sfr.
// Notes:   Table words are a fixed function of the pointer value.
`timescale 1ns/1ns
module csf_prog_model (
  // Clock and reset.
  input  wire logic        clk_sys_i,
  input  wire logic        reset_i,
  // Table pointer from the registers.
  input  wire logic [15:0] tbl_ptr_i,
  output logic [15:0]      tbl_word_o,
  // Program counter low byte.
  input  wire logic        jump_i,
  input  wire logic [7:0]  jump_target_i,
  output logic [7:0]       pc_low_o
);
  logic [7:0] pc_low_ff;

  // The program word changes with every pointer bit, so stale pointers show up.
  assign tbl_word_o = {tbl_ptr_i[7:0] ^ 8'h1c, tbl_ptr_i[15:8] ^ 8'h09};
  assign pc_low_o   = pc_low_ff;

  always_ff @(posedge clk_sys_i or posedge reset_i) begin
    if (reset_i) begin
      pc_low_ff <= 8'h00;
    end else if (jump_i) begin
      pc_low_ff <= jump_target_i;
    end
  end
endmodule : csf_prog_model

// [csf_sfr.sv]
// Purpose: Special function registers and bank-0 data memory of the core.
// Assumes: The execution unit drives one access source per cycle.
// Notes:   Read data appears one enabled cycle after the read request.
//
// Functional notes
// RULE1 - Accesses to the indirect access port act on the location in the pointer.
// RULE2 - Indirect port itself reads 00H and ignores writes.
// RULE3 - Memory pointer is a real read/write register reaching bank 0 only.
// RULE4 - Writing the low program counter byte jumps within the current page.
// RULE5 - A program counter low byte write inserts one dummy cycle.
// RULE6 - Table read puts high program byte in latch, low byte in memory.
// RULE7 - Software loads both table pointers before any table read.
// RULE8 - Status writes never change the time-out and power-down flags.
// RULE9 - Time-out flag set by watchdog expiry, cleared by reset, clear or sleep.
// RULE10 - Power-down flag set by sleep, cleared by reset or watchdog clear.
// RULE11 - Carry is carry-out or no-borrow; rotates through carry update it.
// RULE12 - Half carry is low nibble carry or no nibble borrow.
// RULE13 - Zero flag follows whether a result equals zero.
// RULE14 - Overflow is carry into top bit differing from carry out.
// RULE15 - Status bits 7 and 6 read zero; system flags read-only, reset zero.
// RULE16 - Interrupts and calls never save the status register.
// RULE17 - Results go to the working register; no register-to-register move. The code sends ALU results to memory when alu_to_mem_i is set.
// RULE18 - Result flags win over a same-instruction write to arithmetic flags.
`timescale 1ns/1ns
module csf_sfr
  import csf_pkg::*;
#(
  parameter int unsigned PROG_W = 16,
  parameter int unsigned GP_DEPTH = 64
)(
  // Clock, reset and enable.
  input  wire logic              clk_sys_i,
  input  wire logic              reset_i,
  input  wire logic              clk_en_i,
  // Data memory access from the execution unit.
  input  wire logic [6:0]        mem_addr_i,
  input  wire logic              mem_rd_i,
  input  wire logic              mem_wr_i,
  output logic [7:0]             mem_rdata_o,
  // Arithmetic and logic unit request.
  input  wire logic              alu_en_i,
  input  wire csf_alu_op_t       alu_op_i,
  input  wire logic [7:0]        alu_b_i,
  input  wire logic              alu_to_mem_i,
  output logic [7:0]             working_register_a_o,
  // Table read.
  input  wire logic              tbl_rd_i,
  input  wire logic [PROG_W-1:0] tbl_word_i,
  output logic [15:0]            tbl_ptr_o,
  // Program counter.
  input  wire logic [7:0]        pc_low_i,
  output logic                   jump_o,
  output logic [7:0]             jump_target_o,
  output logic                   stall_o,
  // System events and status.
  input  wire logic              wdt_expired_i,
  input  wire logic              watchdog_clear_instruction_i,
  input  wire logic              sleep_instruction_i,
  output logic [7:0]             status_o
);

  // Registers.
  logic [7:0]  memory_pointer_zero_ff;
  logic [7:0]  working_register_a_ff;
  logic [7:0]  tbl_ptr_low_ff;
  logic [7:0]  tbl_ptr_high_ff;
  logic [7:0]  table_read_high_latch_ff;
  logic [3:0]  arith_flags_ff;
  logic        watchdog_timeout_flag_ff;
  logic        power_down_flag_ff;
  logic [7:0]  rdata_ff;
  logic        jump_ff;
  logic        stall_ff;
  logic [7:0]  jump_target_ff;
  logic [7:0]  gp_mem [GP_DEPTH];

  // Address resolution and decode.
  logic        via_port;
  logic [6:0]  eff_addr;
  logic [5:0]  gp_idx;
  logic        hit_gp;
  logic        wr_any;
  logic [7:0]  wr_data;
  logic        wr_mp0;
  logic        wr_acc;
  logic        wr_pcl;
  logic        wr_tblp;
  logic        wr_tbhp;
  logic        wr_status;
  logic        wr_gp;
  logic        alu_go;
  logic [7:0]  alu_res;
  logic [3:0]  alu_flag;
  logic [3:0]  alu_upd;
  logic [7:0]  rd_mux;
  logic [7:0]  status_view;

  // Every access to the port is steered to the pointer's bank-0 address.
  assign via_port = (mem_addr_i == CSF_ADDR_IAP);                       // [RULE1]
  assign eff_addr = via_port ? memory_pointer_zero_ff[6:0] : mem_addr_i; // [RULE3]
  assign gp_idx   = eff_addr[5:0];
  assign hit_gp   = (eff_addr >= CSF_ADDR_GP);
  assign alu_go   = clk_en_i && alu_en_i;

  // Memory writes carry the working register, an ALU result or table data.
  assign wr_any  = clk_en_i && (mem_wr_i || tbl_rd_i || (alu_en_i && alu_to_mem_i));
  assign wr_data = tbl_rd_i ? tbl_word_i[7:0]                            // [RULE6]
                 : (alu_en_i && alu_to_mem_i) ? alu_res
                 : working_register_a_ff;                                // [RULE17]

  // A write that resolves to the port itself matches no target.
  assign wr_mp0    = wr_any && (eff_addr == CSF_ADDR_MP0);               // [RULE2]
  assign wr_acc    = wr_any && (eff_addr == CSF_ADDR_ACC);
  assign wr_pcl    = wr_any && (eff_addr == CSF_ADDR_PCL);
  assign wr_tblp   = wr_any && (eff_addr == CSF_ADDR_TBLP);
  assign wr_tbhp   = wr_any && (eff_addr == CSF_ADDR_TBHP);
  assign wr_status = wr_any && (eff_addr == CSF_ADDR_STATUS);
  assign wr_gp     = wr_any && hit_gp;

  csf_alu u_alu (
    .op_i    (alu_op_i),
    .a_i     (working_register_a_ff),
    .b_i     (alu_b_i),
    .carry_i (arith_flags_ff[CSF_ST_C]),
    .res_o   (alu_res),
    .flag_o  (alu_flag),
    .upd_o   (alu_upd)
  );

  // Status is assembled from flops; there is no path that pushes it anywhere.
  assign status_view = {CSF_ST_HI_ZERO, watchdog_timeout_flag_ff,
                        power_down_flag_ff, arith_flags_ff};             // [RULE15] [RULE16]

  // Unused special addresses and the port itself read as zero.
  assign rd_mux = hit_gp                          ? gp_mem[gp_idx]
                : (eff_addr == CSF_ADDR_MP0)    ? memory_pointer_zero_ff
                : (eff_addr == CSF_ADDR_ACC)    ? working_register_a_ff
                : (eff_addr == CSF_ADDR_PCL)    ? pc_low_i
                : (eff_addr == CSF_ADDR_TBLP)   ? tbl_ptr_low_ff
                : (eff_addr == CSF_ADDR_TABLE_READ_HIGH_LATCH)   ? table_read_high_latch_ff
                : (eff_addr == CSF_ADDR_TBHP)   ? tbl_ptr_high_ff
                : (eff_addr == CSF_ADDR_STATUS) ? status_view
                : CSF_BYTE_ZERO;                                         // [RULE2]

  // Pointer registers.
  always_ff @(posedge clk_sys_i or posedge reset_i) begin
    if (reset_i) begin
      memory_pointer_zero_ff <= CSF_BYTE_ZERO;
      tbl_ptr_low_ff         <= CSF_BYTE_ZERO;
      tbl_ptr_high_ff        <= CSF_BYTE_ZERO;
    end else begin
      if (wr_mp0) memory_pointer_zero_ff <= wr_data;                    // [RULE3]
      if (wr_tblp) tbl_ptr_low_ff <= wr_data;
      if (wr_tbhp) tbl_ptr_high_ff <= wr_data;
    end
  end

  // Working register takes ALU results or a mapped write.
  always_ff @(posedge clk_sys_i or posedge reset_i) begin
    if (reset_i) begin
      working_register_a_ff <= CSF_BYTE_ZERO;
    end else if (alu_go && !alu_to_mem_i) begin
      working_register_a_ff <= alu_res;                                  // [RULE17]
    end else if (wr_acc) begin
      working_register_a_ff <= wr_data;
    end
  end

  // The high latch is loaded only by a table read, never by a write.
  always_ff @(posedge clk_sys_i or posedge reset_i) begin
    if (reset_i) begin
      table_read_high_latch_ff <= CSF_BYTE_ZERO;
    end else if (clk_en_i && tbl_rd_i) begin
      table_read_high_latch_ff <= 8'(tbl_word_i[PROG_W-1:8]);           // [RULE6]
    end
  end

  // Arithmetic flags power up unknown, so they carry no reset.
  always_ff @(posedge clk_sys_i) begin
    if (wr_status || alu_go) begin
      for (int i = 0; i < CSF_ARITH_W; i++) begin
        if (alu_go && alu_upd[i]) begin
          arith_flags_ff[i] <= alu_flag[i];                              // [RULE18]
        end else if (wr_status) begin
          arith_flags_ff[i] <= wr_data[i];                               // [RULE8]
        end
      end
    end
  end

  // System flags ignore status writes; an expiry wins over a clear.
  always_ff @(posedge clk_sys_i or posedge reset_i) begin
    if (reset_i) begin
      watchdog_timeout_flag_ff <= CSF_SYS_FLAG_RST;                      // [RULE15]
      power_down_flag_ff       <= CSF_SYS_FLAG_RST;
    end else if (clk_en_i) begin
      if (wdt_expired_i) begin
        watchdog_timeout_flag_ff <= 1'b1;                                // [RULE9]
      end else if (watchdog_clear_instruction_i || sleep_instruction_i) begin
        watchdog_timeout_flag_ff <= 1'b0;                                // [RULE9]
      end
      if (sleep_instruction_i) begin
        power_down_flag_ff <= 1'b1;                                      // [RULE10]
      end else if (watchdog_clear_instruction_i) begin
        power_down_flag_ff <= 1'b0;                                      // [RULE10]
      end
    end
  end

  // Program counter low byte write: jump within the page plus a dummy cycle.
  always_ff @(posedge clk_sys_i or posedge reset_i) begin
    if (reset_i) begin
      jump_ff        <= 1'b0;
      stall_ff       <= 1'b0;
      jump_target_ff <= CSF_BYTE_ZERO;
    end else if (clk_en_i) begin
      jump_ff  <= wr_pcl;                                                // [RULE4]
      stall_ff <= wr_pcl;                                                // [RULE5]
      if (wr_pcl) jump_target_ff <= wr_data;                             // [RULE4]
    end
  end

  // Read data register.
  always_ff @(posedge clk_sys_i or posedge reset_i) begin
    if (reset_i) begin
      rdata_ff <= CSF_BYTE_ZERO;
    end else if (clk_en_i && mem_rd_i) begin
      rdata_ff <= rd_mux;                                                // [RULE1]
    end
  end

  // General purpose memory.
  always_ff @(posedge clk_sys_i) begin
    if (wr_gp) gp_mem[gp_idx] <= wr_data;                                // [RULE1]
  end

  assign mem_rdata_o          = rdata_ff;
  assign working_register_a_o = working_register_a_ff;
  assign tbl_ptr_o            = {tbl_ptr_high_ff, tbl_ptr_low_ff};       // [RULE7]
  assign jump_o               = jump_ff;
  assign jump_target_o        = jump_target_ff;
  assign stall_o              = stall_ff;
  assign status_o             = status_view;

  // Checks.
  property p_port_self_zero;
    @(posedge clk_sys_i) disable iff (reset_i)
    (clk_en_i && mem_rd_i && via_port && memory_pointer_zero_ff[6:0] == CSF_ADDR_IAP)
      |=> (mem_rdata_o == CSF_BYTE_ZERO);
  endproperty
  a_port_self_zero: assert property (p_port_self_zero) // [RULE2]
    else $error("Port read through itself did not return zero.");

  property p_indirect_write;
    @(posedge clk_sys_i) disable iff (reset_i)
    (clk_en_i && mem_wr_i && !tbl_rd_i && !alu_en_i && via_port
      && memory_pointer_zero_ff[6:0] >= CSF_ADDR_GP)
      |=> (gp_mem[$past(memory_pointer_zero_ff[5:0])] == $past(working_register_a_ff));
  endproperty
  a_indirect_write: assert property (p_indirect_write) // [RULE1]
    else $error("Indirect write did not reach the pointed location.");

  property p_pointer_rw;
    @(posedge clk_sys_i) disable iff (reset_i)
    (wr_mp0 && mem_wr_i && !tbl_rd_i && !alu_en_i)
      |=> (memory_pointer_zero_ff == $past(working_register_a_ff));
  endproperty
  a_pointer_rw: assert property (p_pointer_rw) // [RULE3]
    else $error("Memory pointer did not take the written value.");

  property p_jump;
    @(posedge clk_sys_i) disable iff (reset_i)
    wr_pcl |=> (jump_o && jump_target_o == $past(wr_data));
  endproperty
  a_jump: assert property (p_jump) // [RULE4]
    else $error("Program counter low write did not jump to its value.");

  property p_dummy_cycle;
    @(posedge clk_sys_i) disable iff (reset_i)
    (wr_pcl ##1 clk_en_i) |-> stall_o ##1 !stall_o;
  endproperty
  a_dummy_cycle: assert property (p_dummy_cycle) // [RULE5]
    else $error("Dummy cycle was not exactly one cycle long.");

  property p_table_high;
    @(posedge clk_sys_i) disable iff (reset_i)
    (clk_en_i && tbl_rd_i) |=> (table_read_high_latch_ff == 8'($past(tbl_word_i[PROG_W-1:8])));
  endproperty
  a_table_high: assert property (p_table_high) // [RULE6]
    else $error("Table read high byte not latched.");

  property p_status_write_keeps;
    @(posedge clk_sys_i) disable iff (reset_i)
    (wr_status && !wdt_expired_i && !watchdog_clear_instruction_i && !sleep_instruction_i)
      |=> ($stable(watchdog_timeout_flag_ff) && $stable(power_down_flag_ff));
  endproperty
  a_status_write_keeps: assert property (p_status_write_keeps) // [RULE8]
    else $error("Status write changed a system flag.");

  property p_timeout_set;
    @(posedge clk_sys_i) disable iff (reset_i)
    (clk_en_i && wdt_expired_i) |=> status_o[CSF_ST_TO];
  endproperty
  a_timeout_set: assert property (p_timeout_set) // [RULE9]
    else $error("Watchdog expiry did not set the time-out flag.");

  property p_sleep_flags;
    @(posedge clk_sys_i) disable iff (reset_i)
    (clk_en_i && sleep_instruction_i && !wdt_expired_i)
      |=> (status_o[CSF_ST_PDF] && !status_o[CSF_ST_TO]);
  endproperty
  a_sleep_flags: assert property (p_sleep_flags) // [RULE10]
    else $error("Sleep did not set power-down and clear time-out.");

  property p_zero_flag;
    @(posedge clk_sys_i) disable iff (reset_i)
    (alu_go && !alu_to_mem_i && alu_op_i == CSF_OP_ADD)
      |=> (status_o[CSF_ST_Z] == (working_register_a_o == CSF_BYTE_ZERO));
  endproperty
  a_zero_flag: assert property (p_zero_flag) // [RULE13]
    else $error("Zero flag does not match the addition result.");

  property p_high_bits_zero;
    @(posedge clk_sys_i) disable iff (reset_i)
    (clk_en_i && mem_rd_i && eff_addr == CSF_ADDR_STATUS)
      |=> (mem_rdata_o[7:6] == CSF_ST_HI_ZERO);
  endproperty
  a_high_bits_zero: assert property (p_high_bits_zero) // [RULE15]
    else $error("Unimplemented status bits are not zero.");

  property p_rotate_carry;
    @(posedge clk_sys_i) disable iff (reset_i)
    (alu_go && alu_op_i == CSF_OP_RLC) |=> (status_o[CSF_ST_C] == $past(alu_b_i[7]));
  endproperty
  a_rotate_carry: assert property (p_rotate_carry) // [RULE11]
    else $error("Rotate left did not move the top bit into carry.");

  property p_flag_priority;
    @(posedge clk_sys_i) disable iff (reset_i)
    (alu_go && alu_to_mem_i && wr_status && alu_op_i == CSF_OP_ADD)
      |=> (status_o[CSF_ST_Z] == ($past(alu_res) == CSF_BYTE_ZERO));
  endproperty
  a_flag_priority: assert property (p_flag_priority) // [RULE18]
    else $error("Status write overrode a result flag.");

  property p_acc_result;
    @(posedge clk_sys_i) disable iff (reset_i)
    (alu_go && !alu_to_mem_i) |=> (working_register_a_o == $past(alu_res));
  endproperty
  a_acc_result: assert property (p_acc_result) // [RULE17]
    else $error("Working register did not take the ALU result.");

endmodule : csf_sfr

// [csf_sfr_test.sv]
// Purpose: Self-checking bench of the special function registers.
// Assumes: Memory writes carry the working register, loaded by a pass operation.
// Notes:   Each request is held from one rising edge to the next.
`timescale 1ns/1ns
`define CHK(got, exp) begin checks_done++; if ((got) !== (exp)) begin miscompares++; \
  $display("[FAIL] t=%0t got=%0h exp=%0h", $time, (got), (exp)); end end
module csf_sfr_test;
  import csf_pkg::*;
  logic        clk_sys_i, reset_i, clk_en, mem_rd, mem_wr, alu_en, alu_to_mem, tbl_rd;
  logic        wdt_exp, wdt_clr, sleep_ins, jump_o, stall_o;
  logic [6:0]  mem_addr;
  logic [7:0]  alu_b, mem_rdata_o, acc_o, pc_low, jump_target_o, status_o;
  logic [15:0] tbl_word, tbl_ptr_o;
  csf_alu_op_t alu_op;
  int          miscompares;
  int          checks_done;
  // Entries: operation, a, b, result, flags {ov,z,ac,c}, flag mask.
  localparam logic [34:0] ALU_TAB [10] = '{
    {CSF_OP_ADD,  8'hff, 8'h01, 8'h00, 4'h7, 4'hf}, {CSF_OP_ADD, 8'h7f, 8'h01, 8'h80, 4'ha, 4'hf},
    {CSF_OP_SUB,  8'h05, 8'h05, 8'h00, 4'h7, 4'hf}, {CSF_OP_SUB, 8'h00, 8'h01, 8'hff, 4'h0, 4'hf},
    {CSF_OP_AND,  8'hf0, 8'h0f, 8'h00, 4'h4, 4'h4}, {CSF_OP_OR,  8'h00, 8'h00, 8'h00, 4'h4, 4'h4},
    {CSF_OP_XOR,  8'h55, 8'haa, 8'hff, 4'h0, 4'h4}, {CSF_OP_RLC, 8'h00, 8'h81, 8'h02, 4'h1, 4'h1},
    {CSF_OP_RRC,  8'h00, 8'h01, 8'h80, 4'h1, 4'h1}, {CSF_OP_PASS, 8'h00, 8'h3c, 8'h3c, 4'h0, 4'h0}};

  csf_sfr dut (
    .clk_sys_i(clk_sys_i), .reset_i(reset_i), .clk_en_i(clk_en),
    .mem_addr_i(mem_addr), .mem_rd_i(mem_rd), .mem_wr_i(mem_wr), .mem_rdata_o(mem_rdata_o),
    .alu_en_i(alu_en), .alu_op_i(alu_op), .alu_b_i(alu_b), .alu_to_mem_i(alu_to_mem),
    .working_register_a_o(acc_o), .tbl_rd_i(tbl_rd), .tbl_word_i(tbl_word),
    .tbl_ptr_o(tbl_ptr_o), .pc_low_i(pc_low), .jump_o(jump_o),
    .jump_target_o(jump_target_o), .stall_o(stall_o), .wdt_expired_i(wdt_exp),
    .watchdog_clear_instruction_i(wdt_clr), .sleep_instruction_i(sleep_ins),
    .status_o(status_o));

  csf_prog_model prog (
    .clk_sys_i(clk_sys_i), .reset_i(reset_i), .tbl_ptr_i(tbl_ptr_o), .tbl_word_o(tbl_word),
    .jump_i(jump_o), .jump_target_i(jump_target_o), .pc_low_o(pc_low));

  initial begin
    clk_sys_i = 1'b0;
    forever #5 clk_sys_i = ~clk_sys_i;
  end

  task automatic stop_test();
    $display("checks_done=%0d miscompares=%0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : stop_test

  task automatic req(input logic [6:0] ad, input logic rd, input logic wr, input logic tb);
    @(posedge clk_sys_i);
    mem_addr <= ad;
    mem_rd   <= rd;
    mem_wr   <= wr;
    tbl_rd   <= tb;
    @(posedge clk_sys_i);
    mem_rd   <= 1'b0;
    mem_wr   <= 1'b0;
    tbl_rd   <= 1'b0;
    #1;
  endtask : req

  task automatic alu(input csf_alu_op_t op, input logic [7:0] b, input logic tm,
                     input logic [6:0] ad);
    @(posedge clk_sys_i);
    alu_en     <= 1'b1;
    alu_op     <= op;
    alu_b      <= b;
    alu_to_mem <= tm;
    mem_addr   <= ad;
    @(posedge clk_sys_i);
    alu_en     <= 1'b0;
    alu_to_mem <= 1'b0;
    #1;
  endtask : alu

  task automatic wr(input logic [6:0] ad, input logic [7:0] v);
    alu(CSF_OP_PASS, v, 1'b0, 7'h00);
    req(ad, 1'b0, 1'b1, 1'b0);
  endtask : wr

  task automatic chk_rd(input logic [6:0] ad, input logic [7:0] exp);
    req(ad, 1'b1, 1'b0, 1'b0);
    `CHK(mem_rdata_o, exp)
  endtask : chk_rd

  task automatic sys(input logic [2:0] s, input logic [1:0] exp);
    @(posedge clk_sys_i);
    {wdt_exp, wdt_clr, sleep_ins} <= s;
    @(posedge clk_sys_i);
    {wdt_exp, wdt_clr, sleep_ins} <= 3'h0;
    #1;
    `CHK(status_o[5:4], exp)
  endtask : sys

  initial begin
    #20000;
    miscompares++;
    stop_test();
  end

  initial begin
    miscompares = 0;
    checks_done = 0;
    reset_i = 1'b1;
    clk_en = 1'b1;
    {mem_rd, mem_wr, alu_en, alu_to_mem, tbl_rd, wdt_exp, wdt_clr, sleep_ins} = 8'h00;
    mem_addr = 7'h00;
    alu_b = 8'h00;
    alu_op = CSF_OP_PASS;
    repeat (3) @(posedge clk_sys_i);
    reset_i <= 1'b0;
    #1;
    `CHK(status_o[7:4], 4'h0)
    `CHK({acc_o, tbl_ptr_o, jump_o, stall_o}, 26'h0)
    wr(CSF_ADDR_STATUS, 8'hff);
    `CHK(status_o, 8'h0f)
    chk_rd(CSF_ADDR_STATUS, 8'h0f);
    wr(CSF_ADDR_GP, 8'h3c);
    wr(CSF_ADDR_MP0, 8'h40);
    chk_rd(CSF_ADDR_MP0, 8'h40);
    chk_rd(CSF_ADDR_IAP, 8'h3c);
    wr(CSF_ADDR_IAP, 8'h99);
    chk_rd(CSF_ADDR_GP, 8'h99);
    wr(CSF_ADDR_MP0, 8'hc0);
    chk_rd(CSF_ADDR_IAP, 8'h99);
    wr(CSF_ADDR_MP0, 8'h00);
    chk_rd(CSF_ADDR_IAP, 8'h00);
    wr(CSF_ADDR_IAP, 8'h77);
    chk_rd(CSF_ADDR_MP0, 8'h00);
    chk_rd(CSF_ADDR_GP, 8'h99);
    wr(7'h02, 8'h5a);
    chk_rd(7'h02, 8'h00);
    // A frozen clock enable must drop the whole write.
    @(posedge clk_sys_i);
    clk_en <= 1'b0;
    wr(CSF_ADDR_GP, 8'h11);
    @(posedge clk_sys_i);
    clk_en <= 1'b1;
    chk_rd(CSF_ADDR_GP, 8'h99);
    `CHK(acc_o, 8'h5a)
    wr(CSF_ADDR_PCL, 8'h20);
    `CHK({jump_o, stall_o, jump_target_o}, 10'h320)
    @(posedge clk_sys_i);
    #1;
    `CHK({jump_o, stall_o}, 2'h0)
    chk_rd(CSF_ADDR_PCL, 8'h20);
    wr(CSF_ADDR_TBLP, 8'h06);
    wr(CSF_ADDR_TBHP, 8'h03);
    `CHK(tbl_ptr_o, 16'h0306)
    req(7'h41, 1'b0, 1'b0, 1'b1);
    chk_rd(CSF_ADDR_TABLE_READ_HIGH_LATCH, 8'h1a);
    chk_rd(7'h41, 8'h0a);
    wr(CSF_ADDR_TABLE_READ_HIGH_LATCH, 8'h55);
    chk_rd(CSF_ADDR_TABLE_READ_HIGH_LATCH, 8'h1a);
    for (int i = 0; i < 10; i++) begin
      alu(CSF_OP_PASS, ALU_TAB[i][31:24], 1'b0, 7'h00);
      alu(csf_alu_op_t'(ALU_TAB[i][34:32]), ALU_TAB[i][23:16], 1'b0, 7'h00);
      `CHK(acc_o, ALU_TAB[i][15:8])
      `CHK(status_o[3:0] & ALU_TAB[i][3:0], ALU_TAB[i][7:4] & ALU_TAB[i][3:0])
    end
    alu(CSF_OP_PASS, 8'hff, 1'b0, 7'h00);
    alu(CSF_OP_ADD, 8'h01, 1'b1, CSF_ADDR_STATUS);
    `CHK(status_o[3:0], 4'h7)
    `CHK(acc_o, 8'hff)
    alu(CSF_OP_PASS, 8'h10, 1'b0, 7'h00);
    alu(CSF_OP_ADD, 8'h05, 1'b1, 7'h42);
    chk_rd(7'h42, 8'h15);
    sys(3'b001, 2'b01);
    sys(3'b100, 2'b11);
    sys(3'b001, 2'b01);
    wr(CSF_ADDR_STATUS, 8'h00);
    `CHK(status_o[5:4], 2'b01)
    sys(3'b110, 2'b10);
    sys(3'b010, 2'b00);
    sys(3'b101, 2'b11);
    wr(CSF_ADDR_MP0, 8'h41);
    // A reset in mid-run must clear the system flags, pointer and working register.
    @(posedge clk_sys_i);
    reset_i <= 1'b1;
    repeat (2) @(posedge clk_sys_i);
    reset_i <= 1'b0;
    #1;
    `CHK({status_o[7:4], acc_o}, 12'h000)
    chk_rd(CSF_ADDR_MP0, 8'h00);
    stop_test();
  end
endmodule : csf_sfr_test
